// [core/pdms_pkg.sv]
// shared types and constants for the phy data path mode steering block
package pdms_pkg;

  // ------------------------------------------------------------
  // widths, depths and line/host rates (kbps)
  // ------------------------------------------------------------
  localparam int DATA_W         = 32;
  localparam int RCF_DEPTH      = 4;
  localparam int LINE_LAN_KBPS  = 10312500;
  localparam int LINE_WAN_KBPS  = 9953280;
  localparam int LINE_GBE_KBPS  = 1250000;
  localparam int HOST_XAUI_KBPS = 3125000;
  localparam int HOST_RX_KBPS   = 6250000;
  localparam int HOST_GBE_KBPS  = 1250000;

  // ------------------------------------------------------------
  // lane masks and rate codes
  // ------------------------------------------------------------
  localparam logic [3:0] LANES_XAUI  = 4'hF;
  localparam logic [3:0] LANES_RXAUI = 4'h5;
  localparam logic [3:0] LANES_GBE_0 = 4'h1;
  localparam logic [3:0] LANES_GBE_3 = 4'h8;
  localparam logic [1:0] LRATE_LAN   = 2'h0;
  localparam logic [1:0] LRATE_WAN   = 2'h1;
  localparam logic [1:0] LRATE_GBE   = 2'h2;
  localparam logic [1:0] HRATE_XAUI  = 2'h0;
  localparam logic [1:0] HRATE_RXAUI = 2'h1;
  localparam logic [1:0] HRATE_GBE   = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PDMS_LAN, PDMS_WAN, PDMS_GBE} pdms_mode_t;

  typedef struct packed {
    logic gbe_sel;
    logic wan_path_enable;
    logic rxaui_sel;
    logic lane3_sel;
    logic ptp_en;
    logic sec_en;
    logic mac_en;
    logic xc_bcast;
  } pdms_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } pdms_word_t;

  typedef struct packed {
    logic       rx_wis;
    logic       rx_pcs10;
    logic       rx_pcs1g_line;
    logic       tx_wis;
    logic       tx_pcs10;
    logic       tx_pcs1g_line;
    logic       xgxs_en;
    logic       host_pcs1g_en;
    logic       line_pcs1g_en;
    logic [3:0] host_tx_lanes;
    logic [3:0] host_rx_lanes;
    logic [1:0] line_rate;
    logic [1:0] host_rate;
    logic       ptp_in;
    logic       sec_in;
    logic       mac_in;
    logic       fcb_en;
    logic       xc_to_host;
    logic       xc_to_line;
    logic       wan_active;
    logic       kr_clk_hi;
  } pdms_path_t;

  typedef struct packed {
    pdms_cfg_t  cfg;
    pdms_path_t path;
    pdms_word_t line_tx;
    logic       flush;
  } pdms_top_st_t;

endpackage : pdms_pkg

// [core/pdms_steering.sv]
// rate fifo and top-level mode steering of the phy data path
// Contract
// R1: line sender delivers per-mode coding and rate
// R2: wan receive passes through wan sublayer
// R3: lan to 10g pcs, 1g to line pcs
// R4: timing, security, mac stages individually bypassable
// R5: 10g host side xgxs, four or two lanes
// R6: rxaui uses only lanes 0 and 2
// R7: 1g uses lane 0 or 3, both directions
// R8: 1g host side coded by host 1g pcs
// R9: 10g transmit decodes and aligns in xgxs
// R10: 10g transmit 64b/66b coded, lan rate
// R11: wan transmit builds frames at wan rate
// R12: 1g transmit host decode, line re-encode
// R13: 10g mac only together with security
// R14: cross connect broadcasts line to host only
// R15: switchover may disrupt data
// R16: rate compensating fifo between line and host
// R17: flow buffer compensates when macs enabled
// R18: host and line 1g pcs instances
// R19: kr taps clock 10 ghz or 1 ghz
// R20: one wan enable for both directions
// R21: mode and host type drive all muxes
`timescale 1ns/100ps
`default_nettype none

module pdms_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    in_ready;
    logic                    out_valid;
  } pdms_fifo_st_t;

  pdms_fifo_st_t st_ff;
  pdms_fifo_st_t nxt_st;
  logic          push;
  logic          pop;

  // ------------------------------------------------------------
  // pointer and level update
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    push   = in_valid & st_ff.in_ready;
    pop    = st_ff.out_valid & out_ready;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = st_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + AW'(1);
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // reconfiguration drops buffered words
    if (flush) begin
      nxt_st.wp  = '0;
      nxt_st.rp  = '0;
      nxt_st.cnt = '0;
    end
    nxt_st.in_ready  = (nxt_st.cnt != (AW+1)'(DEPTH));
    nxt_st.out_valid = (nxt_st.cnt != '0);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff          <= '0;
      st_ff.in_ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready  = st_ff.in_ready;
  assign out_valid = st_ff.out_valid;
  assign out_data  = st_ff.mem[st_ff.rp];

endmodule : pdms_fifo

module pdms_steering (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  pdms_pkg::pdms_cfg_t  cfg,
  input  pdms_pkg::pdms_word_t line_rx,
  input  pdms_pkg::pdms_word_t adj_line_rx,
  output logic              line_rx_ready,
  output pdms_pkg::pdms_word_t host_tx,
  input  wire logic         host_tx_ready,
  input  pdms_pkg::pdms_word_t host_rx,
  output pdms_pkg::pdms_word_t line_tx,
  output pdms_pkg::pdms_path_t path
);
  import pdms_pkg::*;

  pdms_top_st_t st_ff;
  pdms_top_st_t nxt_st;
  pdms_word_t   ing_src;
  logic         rcf_in_valid;

  // ------------------------------------------------------------
  // mode and path decode
  // ------------------------------------------------------------
  function automatic pdms_mode_t mode_of(input pdms_cfg_t c);
    if (c.gbe_sel) begin
      mode_of = PDMS_GBE;
    end else if (c.wan_path_enable) begin
      mode_of = PDMS_WAN; // [R20]
    end else begin
      mode_of = PDMS_LAN;
    end
  endfunction : mode_of

  function automatic pdms_path_t path_of(input pdms_cfg_t c);
    pdms_path_t p;
    pdms_mode_t m;
    logic       ten;
    logic [3:0] lanes;
    p   = '0;
    m   = mode_of(c); // [R21]
    ten = (m != PDMS_GBE);
    p.rx_wis        = (m == PDMS_WAN); // [R2] [R20]
    p.tx_wis        = (m == PDMS_WAN); // [R11] [R20]
    p.wan_active    = (m == PDMS_WAN); // [R20]
    p.rx_pcs10      = ten; // [R2] [R3]
    p.tx_pcs10      = ten; // [R10]
    p.rx_pcs1g_line = !ten; // [R3]
    p.tx_pcs1g_line = !ten; // [R12]
    p.line_pcs1g_en = !ten; // [R18]
    p.host_pcs1g_en = !ten; // [R8] [R12] [R18]
    p.xgxs_en       = ten; // [R5] [R9]
    case (m)
      PDMS_LAN: begin
        p.line_rate = LRATE_LAN; // [R10]
      end
      PDMS_WAN: begin
        p.line_rate = LRATE_WAN; // [R11]
      end
      default: begin
        p.line_rate = LRATE_GBE; // [R12]
      end
    endcase
    if (!ten) begin
      lanes       = c.lane3_sel ? LANES_GBE_3 : LANES_GBE_0; // [R7]
      p.host_rate = HRATE_GBE; // [R8]
    end else if (c.rxaui_sel) begin
      lanes       = LANES_RXAUI; // [R6]
      p.host_rate = HRATE_RXAUI; // [R5]
    end else begin
      lanes       = LANES_XAUI;
      p.host_rate = HRATE_XAUI; // [R5]
    end
    p.host_tx_lanes = lanes; // [R6] [R7]
    p.host_rx_lanes = lanes; // [R6] [R7]
    p.ptp_in        = c.ptp_en; // [R4]
    p.sec_in        = c.sec_en; // [R4]
    // in 10g a mac without security is refused
    p.mac_in        = c.mac_en & (!ten | c.sec_en); // [R4] [R13]
    p.fcb_en        = p.mac_in; // [R17]
    p.xc_to_host    = c.xc_bcast; // [R14]
    p.xc_to_line    = 1'b0; // [R14]
    p.kr_clk_hi     = ten; // [R19]
    path_of = p;
  endfunction : path_of

  // ------------------------------------------------------------
  // state update
  // ------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.cfg   = cfg;
    nxt_st.path  = path_of(cfg); // [R21]
    // any change of configuration is a non-hitless switchover
    nxt_st.flush = (cfg != st_ff.cfg); // [R15]
    // egress: host data never crosses to the adjacent line
    nxt_st.line_tx.valid = host_rx.valid & !st_ff.flush; // [R14] [R9]
    nxt_st.line_tx.data  = host_rx.data;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // ingress rate fifo with cross connect source
  // ------------------------------------------------------------
  always_comb begin
    ing_src      = st_ff.cfg.xc_bcast ? adj_line_rx : line_rx; // [R14]
    rcf_in_valid = ing_src.valid & !st_ff.flush; // [R15]
  end

  pdms_fifo #(
    .W     (DATA_W),
    .DEPTH (RCF_DEPTH)
  ) u_rcf ( // [R16]
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (st_ff.flush),
    .in_valid  (rcf_in_valid),
    .in_data   (ing_src.data),
    .in_ready  (line_rx_ready),
    .out_valid (host_tx.valid),
    .out_data  (host_tx.data),
    .out_ready (host_tx_ready)
  );

  assign line_tx = st_ff.line_tx;
  assign path    = st_ff.path;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  mac_gate_a: assert property ( // [R13]
    path.mac_in && path.xgxs_en |-> path.sec_in)
    else $error("10g mac enabled without security");

  wan_both_a: assert property ( // [R20]
    $past(cfg.wan_path_enable && !cfg.gbe_sel) |->
      path.rx_wis && path.tx_wis && path.wan_active)
    else $error("wan enable not applied to both paths");

  rxaui_lanes_a: assert property ( // [R6]
    !cfg.gbe_sel && cfg.rxaui_sel |=>
      path.host_tx_lanes == 4'h5 && path.host_rx_lanes == 4'h5)
    else $error("rxaui lanes not 0 and 2");

  gbe_lane_a: assert property ( // [R7]
    cfg.gbe_sel |=> path.host_tx_lanes == path.host_rx_lanes &&
      path.host_tx_lanes == ($past(cfg.lane3_sel) ? 4'h8 : 4'h1))
    else $error("1g host lane mismatch");

  lan_route_a: assert property ( // [R3]
    !cfg.gbe_sel && !cfg.wan_path_enable |=>
      path.rx_pcs10 && !path.rx_wis && !path.rx_pcs1g_line)
    else $error("lan receive not routed to 10g pcs");

  gbe_route_a: assert property ( // [R12]
    cfg.gbe_sel |=> path.rx_pcs1g_line && path.host_pcs1g_en &&
      !path.xgxs_en && !path.kr_clk_hi)
    else $error("1g routing wrong");

  xc_dir_a: assert property ( // [R14]
    !path.xc_to_line && (path.xc_to_host == $past(cfg.xc_bcast)))
    else $error("cross connect direction wrong");

  switch_flush_a: assert property ( // [R15]
    rst_n && $past(rst_n) && cfg != st_ff.cfg |=>
      st_ff.flush ##1 !host_tx.valid)
    else $error("switchover did not drop buffer");

  fcb_follow_a: assert property ( // [R17]
    path.fcb_en == path.mac_in)
    else $error("flow buffer not tied to mac");

  rcf_full_a: assert property ( // [R16]
    !line_rx_ready |-> host_tx.valid)
    else $error("fifo full while empty");

  wan_cov_c: cover property (path.wan_active && host_tx.valid);
  gbe3_cov_c: cover property (path.host_tx_lanes == 4'h8 && line_tx.valid);
  full_cov_c: cover property (!line_rx_ready ##1 host_tx_ready);
  xc_cov_c: cover property (path.xc_to_host && host_tx.valid);

endmodule : pdms_steering

`default_nettype wire

// [tb/pdms_host_model.sv]
// host side model: stalls ingress words and sends egress words
`timescale 1ns/100ps
`default_nettype none
module pdms_host_model (
  input  wire logic            clock,
  input  wire logic            en,
  input  wire logic            slow,
  output logic                 host_tx_ready,
  output pdms_pkg::pdms_word_t host_rx
);
  import pdms_pkg::*;
  integer seed = 42446;
  initial begin
    host_tx_ready = 1'b0;
    host_rx       = '0;
  end
  always @(negedge clock) begin
    host_tx_ready <= slow ? ($random(seed) % 4 == 0) : 1'b1;
    host_rx.valid <= en && ($random(seed) % 2 != 0);
    // idle data keeps changing so a stale word never looks good
    host_rx.data  <= en ? DATA_W'($random(seed)) : ~host_rx.data;
  end
endmodule : pdms_host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the mode steering block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pdms_pkg::*;
  logic       clock, rst_n, run, en, slow, host_tx_ready, line_rx_ready;
  logic       full_seen;
  pdms_cfg_t  cfg;
  pdms_word_t line_rx, adj_line_rx, host_tx, host_rx, line_tx;
  pdms_path_t path, ep;
  pdms_word_t ing_q[$];
  pdms_word_t eg_q[$];
  integer     seed = 42446;
  integer     errors = 0;
  integer     samples_checked = 0;

  pdms_steering i_pdms_steering (.clock(clock), .rst_n(rst_n), .cfg(cfg),
    .line_rx(line_rx), .adj_line_rx(adj_line_rx),
    .line_rx_ready(line_rx_ready), .host_tx(host_tx),
    .host_tx_ready(host_tx_ready), .host_rx(host_rx), .line_tx(line_tx),
    .path(path));
  pdms_host_model i_pdms_host_model (.clock(clock), .en(en), .slow(slow),
    .host_tx_ready(host_tx_ready), .host_rx(host_rx));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string what, input logic [32:0] e,
                     input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  function automatic pdms_path_t exp_path(input pdms_cfg_t c);
    pdms_path_t p;
    logic       g;
    logic       w;
    g = c.gbe_sel;
    w = c.wan_path_enable & !g;
    p = '0;
    {p.rx_wis, p.tx_wis, p.wan_active} = {3{w}};
    {p.rx_pcs10, p.tx_pcs10, p.xgxs_en, p.kr_clk_hi} = {4{!g}};
    {p.rx_pcs1g_line, p.tx_pcs1g_line} = {2{g}};
    {p.host_pcs1g_en, p.line_pcs1g_en} = {2{g}};
    p.host_tx_lanes = g ? (c.lane3_sel ? LANES_GBE_3 : LANES_GBE_0)
                        : (c.rxaui_sel ? LANES_RXAUI : LANES_XAUI);
    p.host_rx_lanes = p.host_tx_lanes;
    p.line_rate = g ? LRATE_GBE : (w ? LRATE_WAN : LRATE_LAN);
    p.host_rate = g ? HRATE_GBE : (c.rxaui_sel ? HRATE_RXAUI : HRATE_XAUI);
    p.ptp_in = c.ptp_en;
    p.sec_in = c.sec_en;
    p.mac_in = c.mac_en & (g | c.sec_en);
    p.fcb_en = p.mac_in;
    p.xc_to_host = c.xc_bcast;
    return p;
  endfunction : exp_path

  // line sender: offers a word whenever run is set and the fifo has room
  always @(negedge clock) begin : ing_drv
    pdms_word_t w;
    w.valid = run && line_rx_ready;
    w.data = DATA_W'($random(seed));
    if (run && !line_rx_ready) full_seen <= 1'b1;
    line_rx <= w;
    adj_line_rx <= {w.valid, ~w.data};
    if (w.valid) ing_q.push_back(cfg.xc_bcast ? {1'b1, ~w.data} : w);
  end

  always @(posedge clock) begin
    if (rst_n) begin
      if (line_tx.valid)
        chk("line_tx", eg_q.size() ? eg_q.pop_front() : 33'bx, line_tx);
      if (host_tx.valid && host_tx_ready)
        chk("host_tx", ing_q.size() ? ing_q.pop_front() : 33'bx, host_tx);
      if (host_rx.valid) eg_q.push_back(host_rx);
    end
  end

  initial begin
    {rst_n, run, en, slow, full_seen} = '0;
    cfg = '0;
    line_rx = '0;
    adj_line_rx = '0;
    repeat (4) @(negedge clock);
    chk("ready", 33'(1), 33'(line_rx_ready));
    chk("path", 33'(0), 33'(path));
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(negedge clock);
      cfg <= {i[3:0], 4'($random(seed))};
      slow <= i[4];
      repeat (3) @(negedge clock);
      ep = exp_path(cfg);
      chk("path", 33'(ep), 33'(path));
      chk("lanes", 33'({ep.host_tx_lanes, ep.host_rx_lanes}),
          33'({path.host_tx_lanes, path.host_rx_lanes}));
      chk("stages", 33'({ep.ptp_in, ep.sec_in, ep.mac_in, ep.fcb_en}),
          33'({path.ptp_in, path.sec_in, path.mac_in, path.fcb_en}));
      chk("xconn", 33'({ep.xc_to_host, ep.xc_to_line}),
          33'({path.xc_to_host, path.xc_to_line}));
      chk("wan", 33'({ep.rx_wis, ep.tx_wis, ep.wan_active}),
          33'({path.rx_wis, path.tx_wis, path.wan_active}));
      run <= 1'b1;
      en <= 1'b1;
      repeat (60) @(negedge clock);
      run <= 1'b0;
      en <= 1'b0;
      for (int k = 0; k < 80 && (ing_q.size() + eg_q.size()) > 0; k++)
        @(negedge clock);
      chk("drained", 33'(0), 33'(ing_q.size() + eg_q.size()));
      $display("config %0d done", i);
    end
    chk("fifo full", 33'(1), 33'(full_seen));
    tally_and_finish;
  end

  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
